// File: verif/sfc_osc_rx.sv
// partner: oscillator subsystem receiver on the internal serial link
`timescale 1ns/1ps
module sfc_osc_rx
  import sfc_pkg::*;
(
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // serial link from the bank
  input  wire sfc_link_t   link,
  // captured word
  output logic [15:0]      rx_word,
  output logic             rx_done
);
  logic        last_sclk;  // link clock one cycle ago
  logic        last_frame; // frame level one cycle ago
  logic [15:0] shreg;      // bits gathered so far
  ////////////////////////////////////////////////////////////
  // sample on each link clock rise, first bit ends on top
  always_ff @(posedge clock) begin
    if (rst) begin
      last_sclk  <= 1'b0;
      last_frame <= 1'b0;
      shreg      <= 16'h0000;
      rx_done    <= 1'b0;
      rx_word    <= 16'h0000;
    end else begin
      last_sclk  <= link.sclk;
      last_frame <= link.sframe;
      rx_done    <= last_frame & ~link.sframe;
      if (link.sframe && link.sclk && !last_sclk) begin
        shreg <= {shreg[14:0], link.sdata};
      end
      if (last_frame && !link.sframe) begin
        rx_word <= shreg;
      end
    end
  end
endmodule : sfc_osc_rx

// File: verif/tb_synth_frequency_config_regs.sv
// testbench: synth config bank against a behavioural register model
`timescale 1ns/1ps
module tb_synth_frequency_config_regs;
  import sfc_pkg::*;
  logic              clock, rst, reg_write, reg_read;
  logic [4:0]        reg_addr;
  logic [23:0]       reg_wdata, reg_rdata;
  logic              write_refused, fractional_mode, tune_pulse;
  logic              band_calibration, seed_load, mod_clk_from_osc, rx_done;
  logic [REF_W-1:0]  ref_divide;
  logic [INT_W-1:0]  integer_word;
  logic [FRAC_W-1:0] fraction_word;
  logic [15:0]       rx_word;
  sfc_mod_ctl_t      mod_ctl;
  sfc_link_t         osc_link;
  int miscompares, check_count, lf, c0, cfg, t0, s0, r0, seed_cur;
  int n_tune, n_cal, n_seed, n_ref; // pulse counters
  int mdl [0:31];                   // register model
  int fwd_q [$];                    // words owed to the link
  int stl [4] = '{1032, 2047, 3071, 4095};
  int seeds [4] = '{0, 1, 24'hB29D08, 24'h50F1CD};
  ////////////////////////////////////////////////////////////
  sfc_regs dut (.clock(clock), .rst(rst), .reg_write(reg_write), .reg_read(reg_read),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .write_refused(write_refused), .ref_divide(ref_divide), .integer_word(integer_word),
    .fraction_word(fraction_word), .fractional_mode(fractional_mode),
    .tune_pulse(tune_pulse), .band_calibration(band_calibration), .seed_load(seed_load),
    .mod_ctl(mod_ctl), .mod_clk_from_osc(mod_clk_from_osc), .osc_link(osc_link));
  sfc_osc_rx rx (.clock(clock), .rst(rst), .link(osc_link), .rx_word(rx_word),
    .rx_done(rx_done));
  // free running bank clock
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  ////////////////////////////////////////////////////////////
  function automatic int lfsr(input int s);
    return s[0] ? ((s >> 1) ^ 24'hE10000) : (s >> 1);
  endfunction : lfsr
  // bits that read back as written
  function automatic int msk(input logic [4:0] a);
    case (a)
      5'h02:   return 24'h003FFF;
      5'h03:   return 24'h07FFFF;
      5'h06:   return 24'h3C0F8F;
      default: return 24'hFFFFFF;
    endcase
  endfunction : msk
  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(negedge clock);
  endtask : tick
  // one-cycle write strobe; indirect word kept by caller
  task automatic wr(input logic [4:0] a, input int d);
    @(negedge clock);
    reg_write = 1'b1;
    reg_addr  = a;
    reg_wdata = d[23:0];
    @(negedge clock);
    reg_write = 1'b0;
    if (a >= 5'h02 && a <= 5'h06 && a != ADDR_OSC_IND) mdl[a] = d & 24'hFFFFFF;
  endtask : wr
  task automatic rd(input logic [4:0] a);
    @(negedge clock);
    reg_read = 1'b1;
    reg_addr = a;
    @(negedge clock);
    reg_read = 1'b0;
    @(negedge clock);
    chk("read data", 24'(mdl[a] & msk(a)), reg_rdata & 24'(msk(a)));
  endtask : rd
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : report_and_stop
  // pulse counters and link word checks
  always @(negedge clock) begin
    if (tune_pulse === 1'b1) n_tune++;
    if (band_calibration === 1'b1) n_cal++;
    if (seed_load === 1'b1) n_seed++;
    if (write_refused === 1'b1) n_ref++;
    if (rx_done === 1'b1) chk("link word", fwd_q.pop_front(), {8'h00, rx_word});
  end
  ////////////////////////////////////////////////////////////
  initial begin
    {rst, reg_write, reg_read, reg_addr, reg_wdata} = {3'b100, 5'h00, 24'h000000};
    foreach (mdl[i]) mdl[i] = 0;
    {mdl[2], mdl[3], mdl[6]} = {32'h1, 32'h19, 32'h200B4A};
    {lf, miscompares, check_count, n_tune, n_cal, n_seed, n_ref} = {32'd633, 192'd0};
    tick(4);
    rst = 1'b0;
    // reset values, unmapped places read zero
    for (int a = 0; a < 8; a++) rd(a[4:0]);
    wr(5'h1F, 24'hFFFFFF);
    rd(5'h1F);
    $display("test reset done");
    // divider words with default fractional setup
    {t0, s0} = {n_tune, n_seed};
    for (int i = 0; i < 8; i++) begin
      lf = lfsr(lf);
      // reference buffer enable sits outside this bank and is taken as on
      wr(ADDR_REF_DIV, (lf % 16383) + 1);
      wr(ADDR_INT_WORD, 20 + lf % 524265);
      wr(ADDR_FRAC, lf);
      tick(2);
      chk("ref divide", mdl[2], {10'h000, ref_divide});
      chk("integer word", mdl[3], {5'h00, integer_word});
      chk("fraction word", mdl[4], fraction_word);
      for (int a = 2; a < 5; a++) rd(a[4:0]);
    end
    chk("tune count", t0 + 8, n_tune);
    chk("calibration count", t0 + 8, n_cal);
    chk("seed loads", s0 + 8, n_seed);
    seed_cur = seeds[2];
    chk("seed value", seed_cur, mod_ctl.seed_value);
    $display("test dividers done");
    // every seed, order and self-test length with random modes
    for (int k = 0; k < 16; k++) begin
      lf = lfsr(lf);
      // random auto clock bit: phase detector rate taken at or below 50 MHz
      cfg = (lf & 24'h240F80) | (k & 3) | ((k >> 2) << 2) | ((k & 3) << 19);
      {t0, s0, c0} = {n_tune, n_seed, n_cal};
      wr(ADDR_MOD_CFG, cfg);
      tick(2);
      chk("order", k >> 2, mod_ctl.order);
      chk("use modulator", !cfg[7], mod_ctl.use_modulator);
      chk("clock from osc", cfg[9], mod_ctl.clk_from_osc);
      chk("effective clock", cfg[9] | cfg[10] | cfg[21], mod_clk_from_osc);
      chk("delay pick", cfg[10], mod_ctl.clk_delay_pick);
      chk("core on", cfg[11], mod_ctl.fine_core_on);
      chk("selftest on", cfg[18], mod_ctl.selftest_on);
      chk("selftest length", stl[k & 3], mod_ctl.selftest_length);
      chk("seed held", seed_cur, mod_ctl.seed_value);
      wr(ADDR_FRAC, lf ^ 24'h5A5A5A);
      wr(ADDR_INT_WORD, 20 + lf % 524265);
      tick(3);
      if (cfg[8]) seed_cur = seeds[k & 3];
      chk("seed value", seed_cur, mod_ctl.seed_value);
      chk("seed loads", s0 + cfg[8], n_seed);
      chk("tune count", t0 + 1, n_tune);
      chk("calibration count", c0 + 1, n_cal);
      chk("fraction out", cfg[11] ? mdl[4] : 0, fraction_word);
      chk("fractional mode", cfg[11], fractional_mode);
      rd(ADDR_MOD_CFG);
    end
    $display("test modulator done");
    // indirect word forwarding, second write while busy is dropped
    for (int i = 0; i < 3; i++) begin
      lf = lfsr(lf);
      // target address field kept at zero so a later tune lands right
      mdl[5] = lf & 24'h00FF87;
      fwd_q.push_back(mdl[5]);
      r0 = n_ref;
      wr(ADDR_OSC_IND, lf & 24'hFFFF87);
      tick(3);
      wr(ADDR_OSC_IND, ~lf);
      tick(2);
      chk("refused count", r0 + 1, n_ref);
      rd(ADDR_OSC_IND);
      for (int w = 0; w < 80 && fwd_q.size() > 0; w++) tick(1);
      if (fwd_q.size() > 0) begin
        miscompares++;
        $display("unexpected link word: expected frame end seen none");
        report_and_stop();
      end
      tick(4);
      rd(ADDR_OSC_IND);
    end
    $display("test indirect done");
    report_and_stop();
  end
endmodule : tb_synth_frequency_config_regs

// File: verilog/sfc_pkg.sv
// package: register map, field layout and constants for the synth config bank
package sfc_pkg;
  // register addresses
  localparam logic [4:0] ADDR_REF_DIV  = 5'h02;
  localparam logic [4:0] ADDR_INT_WORD = 5'h03;
  localparam logic [4:0] ADDR_FRAC     = 5'h04;
  localparam logic [4:0] ADDR_OSC_IND  = 5'h05;
  localparam logic [4:0] ADDR_MOD_CFG  = 5'h06;
  // reset values
  localparam logic [23:0] RST_REF_DIV  = 24'h000001;
  localparam logic [23:0] RST_INT_WORD = 24'h000019;
  localparam logic [23:0] RST_FRAC     = 24'h000000;
  localparam logic [23:0] RST_OSC_IND  = 24'h000000;
  localparam logic [23:0] RST_MOD_CFG  = 24'h200B4A;
  // field widths
  localparam int REF_W  = 14;
  localparam int INT_W  = 19;
  localparam int FRAC_W = 24;
  localparam int LINK_W = 16;
  // modulator config field positions
  localparam int SEED_LO     = 0;
  localparam int ORDER_LO    = 2;
  localparam int BYPASS_BIT  = 7;
  localparam int RELOAD_BIT  = 8;
  localparam int CLKSRC_BIT  = 9;
  localparam int DELAY_BIT   = 10;
  localparam int FINE_BIT    = 11;
  localparam int SELFTEST_BIT = 18;
  localparam int STLEN_LO    = 19;
  localparam int AUTOCLK_BIT = 21;
  // seed constants
  localparam logic [23:0] SEED_ZERO = 24'h000000;
  localparam logic [23:0] SEED_LSB  = 24'h000001;
  localparam logic [23:0] SEED_B    = 24'hB29D08;
  localparam logic [23:0] SEED_C    = 24'h50F1CD;
  // self-test lengths in cycles
  localparam logic [11:0] STLEN_0 = 12'h408;
  localparam logic [11:0] STLEN_1 = 12'h7FF;
  localparam logic [11:0] STLEN_2 = 12'hBFF;
  localparam logic [11:0] STLEN_3 = 12'hFFF;
  // link clock divider: not used; the shifter spends two clocks per link bit
  localparam logic [3:0] LINK_DIV = 4'h1;

  // modulator control bundle
  typedef struct packed {
    logic [23:0] seed_value;
    logic [1:0]  order;
    logic        use_modulator;
    logic        clk_from_osc;
    logic        clk_delay_pick;
    logic        fine_core_on;
    logic        selftest_on;
    logic [11:0] selftest_length;
  } sfc_mod_ctl_t;

  // serial link bundle
  typedef struct packed {
    logic sclk;
    logic sdata;
    logic sframe;
  } sfc_link_t;
endpackage : sfc_pkg

// File: verilog/sfc_regs.sv
// module: configuration register bank of the fractional-n synthesizer
`timescale 1ns/1ps
// Functional notes
// - reference divide value, 14 bits, 1..16383
// - integer word 19 bits, resets to 25
// - 24-bit unsigned fractional word over 2^24
// - fractional word used only in fractional mode
// - indirect word: id, address, payload fields
// - each indirect write while the link is idle starts forwarding transfer
// - indirect read returns last forwarded word
// - seed field selects one of four seeds
// - seed reaches modulator only on reload write
// - order field selects modulator type
// - bypass ignores output, modulator keeps clocking
// - reload bit reloads seed on fractional write
// - bit 9 picks clock unless 10/21 set
// - bit 10 picks auxiliary or delayed clock
// - bit 11 enables core, picks calibration trigger
// - bit 18 enables built-in self-test
// - self-test length field 1032..4095 cycles
// - indirect word shifted msb first
// - forwarding link runs on the bank clock
module sfc_regs
  import sfc_pkg::*;
(
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // register port
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  input  wire logic [4:0]  reg_addr,
  input  wire logic [23:0] reg_wdata,
  output logic [23:0]      reg_rdata,
  output logic             write_refused,
  // divider words
  output logic [REF_W-1:0]  ref_divide,
  output logic [INT_W-1:0]  integer_word,
  output logic [FRAC_W-1:0] fraction_word,
  output logic              fractional_mode,
  // tuning events
  output logic              tune_pulse,
  output logic              band_calibration,
  output logic              seed_load,
  // modulator controls
  output sfc_mod_ctl_t      mod_ctl,
  output logic              mod_clk_from_osc,
  // oscillator link
  output sfc_link_t         osc_link
);
  ////////////////////////////////////////////////////////////////
  // storage
  logic [23:0] ref_reg;    // reference divider register
  logic [23:0] int_reg;    // integer word register
  logic [23:0] frac_reg;   // fractional word register
  logic [23:0] ind_reg;    // last forwarded indirect word
  logic [23:0] cfg_reg;    // modulator configuration
  logic        link_busy;  // forwarder still shifting
  logic        fwd_start;  // launch a transfer
  logic [15:0] fwd_word;   // word to forward
  sfc_link_t   link_raw;   // forwarder link

  // decode helper used by the write strobes
  function automatic logic hit(input logic [4:0] a, input logic [4:0] r);
    hit = (a == r);
  endfunction : hit

  // seed table
  function automatic logic [23:0] seed_of(input logic [1:0] sel);
    unique case (sel)
      2'h0: seed_of = SEED_ZERO;
      2'h1: seed_of = SEED_LSB;
      2'h2: seed_of = SEED_B;
      default: seed_of = SEED_C;
    endcase
  endfunction : seed_of

  // self-test length table
  function automatic logic [11:0] stlen_of(input logic [1:0] sel);
    unique case (sel)
      2'h0: stlen_of = STLEN_0;
      2'h1: stlen_of = STLEN_1;
      2'h2: stlen_of = STLEN_2;
      default: stlen_of = STLEN_3;
    endcase
  endfunction : stlen_of

  wire logic wr_ref  = reg_write && hit(reg_addr, ADDR_REF_DIV);
  wire logic wr_int  = reg_write && hit(reg_addr, ADDR_INT_WORD);
  wire logic wr_frac = reg_write && hit(reg_addr, ADDR_FRAC);
  wire logic wr_ind  = reg_write && hit(reg_addr, ADDR_OSC_IND);
  wire logic wr_cfg  = reg_write && hit(reg_addr, ADDR_MOD_CFG);
  wire logic fine_on = cfg_reg[FINE_BIT];

  // seed reload decode, shared by the control path and the checks
  function automatic logic seed_load_now();
    seed_load_now = wr_frac && cfg_reg[RELOAD_BIT];
  endfunction : seed_load_now

  ////////////////////////////////////////////////////////////////
  // plain register writes
  always_ff @(posedge clock) begin
    if (rst) begin
      ref_reg  <= RST_REF_DIV;
      int_reg  <= RST_INT_WORD;
      frac_reg <= RST_FRAC;
      cfg_reg  <= RST_MOD_CFG;
    end else begin
      if (wr_ref) begin
        ref_reg <= {10'h000, reg_wdata[REF_W-1:0]};
      end
      if (wr_int) begin
        int_reg <= {5'h00, reg_wdata[INT_W-1:0]};
      end
      if (wr_frac) begin
        frac_reg <= reg_wdata;
      end
      if (wr_cfg) begin
        cfg_reg <= reg_wdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // indirect word capture and forwarding launch
  assign fwd_start = wr_ind && !link_busy;
  assign fwd_word  = reg_wdata[15:0];

  always_ff @(posedge clock) begin
    if (rst) begin
      ind_reg       <= RST_OSC_IND;
      write_refused <= 1'b0;
    end else begin
      write_refused <= wr_ind && link_busy;
      if (fwd_start) begin
        ind_reg <= {8'h00, fwd_word};
      end
    end
  end

  // forwarder on the bank clock
  sfc_shifter #(
    .WIDTH (LINK_W)
  ) u_shifter (
    .clock (clock),
    .rst   (rst),
    .start (fwd_start),
    .word  (fwd_word),
    .busy  (link_busy),
    .link  (link_raw)
  );

  ////////////////////////////////////////////////////////////////
  // tuning events: calibration trigger and seed reload
  always_ff @(posedge clock) begin
    if (rst) begin
      tune_pulse       <= 1'b0;
      band_calibration <= 1'b0;
      seed_load        <= 1'b0;
    end else begin
      // core on: fractional write tunes; core off: integer write
      tune_pulse       <= fine_on ? wr_frac : wr_int;
      band_calibration <= fine_on ? wr_frac : wr_int;
      seed_load        <= seed_load_now();
    end
  end

  ////////////////////////////////////////////////////////////////
  // divider outputs
  always_ff @(posedge clock) begin
    if (rst) begin
      ref_divide      <= RST_REF_DIV[REF_W-1:0];
      integer_word    <= RST_INT_WORD[INT_W-1:0];
      fraction_word   <= '0;
      fractional_mode <= RST_MOD_CFG[FINE_BIT];
    end else begin
      ref_divide      <= ref_reg[REF_W-1:0];
      integer_word    <= int_reg[INT_W-1:0];
      fractional_mode <= fine_on;
      // integer mode sees a zero fraction
      fraction_word   <= fine_on ? frac_reg : '0;
    end
  end

  ////////////////////////////////////////////////////////////////
  // modulator controls; seed latched only on reload
  always_ff @(posedge clock) begin
    if (rst) begin
      mod_ctl          <= '0;
      mod_clk_from_osc <= 1'b1;
    end else begin
      if (seed_load_now()) begin
        mod_ctl.seed_value <= seed_of(cfg_reg[SEED_LO +: 2]);
      end
      mod_ctl.order           <= cfg_reg[ORDER_LO +: 2];
      mod_ctl.use_modulator   <= !cfg_reg[BYPASS_BIT];
      mod_ctl.clk_from_osc    <= cfg_reg[CLKSRC_BIT];
      mod_ctl.clk_delay_pick  <= cfg_reg[DELAY_BIT];
      mod_ctl.fine_core_on    <= fine_on;
      mod_ctl.selftest_on     <= cfg_reg[SELFTEST_BIT];
      mod_ctl.selftest_length <= stlen_of(cfg_reg[STLEN_LO +: 2]);
      // bit 9 is overridden by delay pick or auto clock
      mod_clk_from_osc <= (cfg_reg[DELAY_BIT] || cfg_reg[AUTOCLK_BIT])
                          ? 1'b1 : cfg_reg[CLKSRC_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////
  // read path and link register
  always_ff @(posedge clock) begin
    if (rst) begin
      reg_rdata <= '0;
      osc_link  <= '0;
    end else begin
      osc_link <= link_raw;
      if (reg_read) begin
        unique case (reg_addr)
          ADDR_REF_DIV:  reg_rdata <= ref_reg;
          ADDR_INT_WORD: reg_rdata <= int_reg;
          ADDR_FRAC:     reg_rdata <= frac_reg;
          ADDR_OSC_IND:  reg_rdata <= ind_reg;
          ADDR_MOD_CFG:  reg_rdata <= cfg_reg;
          default:       reg_rdata <= '0;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // checks: storage and divider outputs
  a_ref_store: assert property (@(posedge clock) disable iff (rst)
    wr_ref |=> ref_reg[REF_W-1:0] == $past(reg_wdata[REF_W-1:0]) && ref_reg[23:14] == 10'h000)
    else $error("reference divide not stored");
  a_int_store: assert property (@(posedge clock) disable iff (rst)
    wr_int |=> ##1 integer_word == $past(reg_wdata[INT_W-1:0], 2))
    else $error("integer word not applied");
  a_frac_store: assert property (@(posedge clock) disable iff (rst)
    wr_frac |=> ##1 !fractional_mode || fraction_word == $past(reg_wdata, 2))
    else $error("fraction word not applied");
  a_frac_gate: assert property (@(posedge clock) disable iff (rst)
    !fractional_mode |-> fraction_word == '0) else $error("fraction leaks in integer mode");

  ////////////////////////////////////////////////////////////////
  // checks: indirect word and forwarding
  a_ind_fields: assert property (@(posedge clock) disable iff (rst)
    fwd_start |=> ind_reg == {8'h00, $past(reg_wdata[15:0])})
    else $error("indirect word not kept");
  a_ind_launch: assert property (@(posedge clock) disable iff (rst)
    fwd_start |=> ##1 osc_link.sframe && osc_link.sdata == $past(reg_wdata[15], 2))
    else $error("forward did not start msb first");
  a_ind_readback: assert property (@(posedge clock) disable iff (rst)
    reg_read && reg_addr == ADDR_OSC_IND |=> reg_rdata == $past(ind_reg))
    else $error("indirect readback wrong");
  a_busy_refuse: assert property (@(posedge clock) disable iff (rst)
    wr_ind && link_busy |=> write_refused && $stable(ind_reg)) else $error("busy write taken");

  ////////////////////////////////////////////////////////////////
  // checks: seed handling
  // a reload write is followed by the load pulse and the table entry
  sequence s_reload_write;
    wr_frac && cfg_reg[RELOAD_BIT];
  endsequence
  sequence s_seed_landed;
    seed_load && mod_ctl.seed_value == seed_of($past(cfg_reg[SEED_LO +: 2]));
  endsequence
  a_seed_hold: assert property (@(posedge clock) disable iff (rst)
    !seed_load_now() |=> $stable(mod_ctl.seed_value)) else $error("seed moved without reload");
  a_seed_value: assert property (@(posedge clock) disable iff (rst)
    seed_load_now() && cfg_reg[1:0] == 2'h2 |=> mod_ctl.seed_value == SEED_B)
    else $error("seed table wrong");
  a_seed_reload: assert property (@(posedge clock) disable iff (rst)
    s_reload_write |=> s_seed_landed) else $error("seed not reloaded");

  ////////////////////////////////////////////////////////////////
  // checks: tuning events and modulator controls
  a_cal_trigger: assert property (@(posedge clock) disable iff (rst)
    wr_int && !fine_on |=> band_calibration) else $error("integer write missed calibration");
  a_cal_fine: assert property (@(posedge clock) disable iff (rst)
    wr_frac && fine_on |=> band_calibration && tune_pulse)
    else $error("fractional write missed calibration");
  a_order_map: assert property (@(posedge clock) disable iff (rst)
    wr_cfg |=> ##1 mod_ctl.order == $past(reg_wdata[ORDER_LO +: 2], 2))
    else $error("modulator order wrong");
  a_bypass_map: assert property (@(posedge clock) disable iff (rst)
    wr_cfg |=> ##1 mod_ctl.use_modulator == !$past(reg_wdata[BYPASS_BIT], 2))
    else $error("bypass flag wrong");
  a_delay_pick: assert property (@(posedge clock) disable iff (rst)
    wr_cfg |=> ##1 mod_ctl.clk_delay_pick == $past(reg_wdata[DELAY_BIT], 2))
    else $error("delay clock pick wrong");
  a_selftest_flag: assert property (@(posedge clock) disable iff (rst)
    wr_cfg |=> ##1 mod_ctl.selftest_on == $past(reg_wdata[SELFTEST_BIT], 2))
    else $error("self-test enable wrong");
  a_clk_override: assert property (@(posedge clock) disable iff (rst)
    cfg_reg[AUTOCLK_BIT] |=> mod_clk_from_osc) else $error("clock select not overridden");
  a_clk_plain: assert property (@(posedge clock) disable iff (rst)
    !cfg_reg[DELAY_BIT] && !cfg_reg[AUTOCLK_BIT]
    |=> mod_clk_from_osc == $past(cfg_reg[CLKSRC_BIT]))
    else $error("clock select not followed");
  a_stlen_map: assert property (@(posedge clock) disable iff (rst)
    cfg_reg[20:19] == 2'h0 && $stable(cfg_reg) |=> mod_ctl.selftest_length == STLEN_0)
    else $error("self-test length wrong");
endmodule : sfc_regs

// File: verilog/sfc_shifter.sv
// module: msb-first serial forwarder for the indirect oscillator word
`timescale 1ns/1ps
module sfc_shifter
  import sfc_pkg::*;
#(
  parameter int WIDTH = LINK_W
) (
  // clock and reset
  input  wire logic             clock,
  input  wire logic             rst,
  // word request
  input  wire logic             start,
  input  wire logic [WIDTH-1:0] word,
  output logic                  busy,
  // serial link
  output sfc_link_t             link
);
  typedef enum logic [2:0] {
    SH_IDLE = 3'b001,
    SH_LOW  = 3'b010,
    SH_HIGH = 3'b100
  } sfc_sh_state_t;

  sfc_sh_state_t    state;  // shift state
  logic [WIDTH-1:0] shreg;  // remaining bits
  logic [4:0]       count;  // bits left

  ////////////////////////////////////////////////////////////////
  // shift sequencer: data on low phase, sampled on rising sclk
  always_ff @(posedge clock) begin
    if (rst) begin
      state <= SH_IDLE;
      shreg <= '0;
      count <= '0;
      busy  <= 1'b0;
      link  <= '0;
    end else begin
      unique case (state)
        SH_IDLE: begin
          link.sclk <= 1'b0;
          if (start) begin
            shreg       <= word << 1;
            link.sdata  <= word[WIDTH-1];
            link.sframe <= 1'b1;
            count       <= 5'(WIDTH);
            busy        <= 1'b1;
            state       <= SH_LOW;
          end else begin
            link.sframe <= 1'b0;
            busy        <= 1'b0;
          end
        end
        SH_LOW: begin
          link.sclk <= 1'b1;
          count     <= count - 5'h01;
          state     <= SH_HIGH;
        end
        SH_HIGH: begin
          link.sclk <= 1'b0;
          if (count == 5'h00) begin
            link.sframe <= 1'b0;
            busy        <= 1'b0;
            state       <= SH_IDLE;
          end else begin
            link.sdata <= shreg[WIDTH-1];
            shreg      <= shreg << 1;
            state      <= SH_LOW;
          end
        end
      endcase
    end
  end

  // a frame stays up at least eight clocks; the shifter holds it two clocks per bit
  a_frame_length: assert property (@(posedge clock) disable iff (rst)
    $rose(link.sframe) |-> link.sframe [*8] ##0 1'b1) else $error("frame too short");
  a_busy_frame: assert property (@(posedge clock) disable iff (rst)
    link.sframe |-> busy) else $error("frame without busy");
endmodule : sfc_shifter
